// ### rtl/trel_top.sv
// The Avalon-MM register port and the register addresses were left to the implementer.
`include "trel_params.svh"

// Functional notes
// - Continuous mode: overflow request on every update
// - One-shot mode: request after one-shot command
// - Overflow request cleared on DMA acknowledge
// - Compare request set on match, acknowledge clears
// - One-shot mode blocks compare channel requests
// - Capture request on valid data, read clears
// - Two-ramp circular channel requests at ramp B
// - Two-ramp circular overflow at ramp A, acked
// - Dual-slope circular channel requests at down-count
// - Dual-slope circular overflow at up-count, acked
// - Each interrupt condition sets a flag; non-recoverable fault events share the NRF0/NRF1 flags
// - Enable set and clear by writing ones
// - Interrupt while enabled flag stays set
// - One shared interrupt line, flags readable
// - Interrupt conditions need the peripheral clock to set flags
// - Output events gated by own enable bits
// - Channel event captures or raises a fault
// - Event one: retrigger, direction, stop, decrement, capture
// - Event zero: retrigger, count, start, increment, active
// - Start on rising edge, later events ignored until count limit
// - Count every prescaled tick while event active
// - Input enable bits gate every incoming event
module trel_top #(parameter int CH = 4) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic upd_ovf,
   input wire logic upd_retrig,
   input wire logic cnt_evt,
   input wire logic cap_err,
   input wire logic dbg_fault,
   input wire logic [1:0] rec_fault,
   input wire logic [1:0] nr_fault,
   input wire logic [CH-1:0] mc_evt,
   input wire logic [CH-1:0] cap_valid,
   input wire logic [CH-1:0] cc_read,
   input wire logic ramp_a_start,
   input wire logic ramp_b_start,
   input wire logic up_start,
   input wire logic down_start,
   input wire logic presc_tick,
   input wire logic count_limit,
   input wire logic dma_ovf_ack,
   input wire logic [CH-1:0] dma_mc_ack,
   output logic dma_ovf_req,
   output logic [CH-1:0] dma_mc_req,
   input wire logic ev_in0,
   input wire logic ev_in1,
   input wire logic [CH-1:0] ev_mc_in,
   output logic ev_ovf_out,
   output logic ev_trg_out,
   output logic ev_cnt_out,
   output logic [CH-1:0] ev_mc_out,
   output logic act_retrig,
   output logic act_dir_down,
   output logic act_stop,
   output logic act_dec,
   output logic act_ppw,
   output logic act_step,
   output logic act_start,
   output logic act_inc,
   output logic act_count,
   output logic [CH-1:0] act_capture,
   output logic [CH-1:0] act_rec_fault,
   output logic irq
);
   import trel_pkg::*;

   localparam int NF = `TREL_INT_MC_LSB + CH;

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic wait_q;
   logic [31:0] rdata_q, rd_mux, wmask;
   logic acc_wr;
   logic [31:0] ctrl_q, event_control_reg_q, chev_q;
   logic [NF-1:0] flag_q, flag_set, en_q;
   logic irq_q;
   logic cmd_pulse_q, os_pend_q, ack_seen_q, ovf_req_q, ovf_set;
   logic [CH-1:0] mc_req_q, mc_set, mc_clr;
   logic [CH+1:0] ev_meta_q, ev_sync_q;
   logic ev_ovf_q, ev_trg_q, ev_cnt_q;
   logic [CH-1:0] ev_mc_q;
   logic dma_one_shot_mode, circ_mode, circ_act, two_ramp, start_a, start_b, any_ack;
   logic [CH-1:0] circ_en, capt_sel;
   trel_wave_e wave;
   trel_ev_if #(.CH(CH)) evi();

   // Reset released through two flops, asserted at once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // Event inputs come from another domain: two flops first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_meta_q <= '0;
         ev_sync_q <= '0;
      end else begin
         ev_meta_q <= {ev_mc_in, ev_in1, ev_in0};
         ev_sync_q <= ev_meta_q;
      end
   end

   // Configuration decode
   assign dma_one_shot_mode = ctrl_q[`TREL_CTRL_DMA_ONE_SHOT_MODE];
   assign wave = trel_wave_e'(ctrl_q[`TREL_CTRL_WAVE_LSB +: 2]);
   assign circ_en = ctrl_q[`TREL_CTRL_CIRC_LSB +: CH];
   assign capt_sel = ctrl_q[`TREL_CTRL_CAPT_LSB +: CH];
   assign two_ramp = wave == WAVE_TWO_RAMP || wave == WAVE_TWO_RAMP_ALT;
   assign circ_mode = two_ramp || wave == WAVE_DUAL_BOTH;
   assign circ_act = circ_mode && |circ_en;
   assign start_a = two_ramp ? ramp_a_start : up_start;
   assign start_b = two_ramp ? ramp_b_start : down_start;
   assign any_ack = dma_ovf_ack || |dma_mc_ack;

   // Avalon slave: answer one cycle after the request
   assign acc_wr = write && !wait_q;
   assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
      {8{byteenable[1]}}, {8{byteenable[0]}}};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wait_q <= 1'b1;
      else
         wait_q <= !((read || write) && wait_q);
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0;
      case (address)
         `TREL_OFS_CTRL: rd_mux = ctrl_q;
         `TREL_OFS_EVENT_CONTROL_REG: rd_mux = event_control_reg_q;
         `TREL_OFS_IRQ_ENABLE_CLEAR_REG: rd_mux[NF-1:0] = en_q;
         `TREL_OFS_IRQ_ENABLE_SET_REG: rd_mux[NF-1:0] = en_q;
         `TREL_OFS_IRQ_FLAG_REG: rd_mux[NF-1:0] = flag_q;
         `TREL_OFS_STATUS: rd_mux[CH+2:0] = {mc_req_q, ovf_req_q, os_pend_q, ack_seen_q};
         `TREL_OFS_CHEV: rd_mux = chev_q;
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data latched as waitrequest drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdata_q <= 32'h0;
      else if (read && wait_q)
         rdata_q <= rd_mux;
   end

   // Plain read/write configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `TREL_RST_REG;
         event_control_reg_q <= `TREL_RST_REG;
         chev_q <= `TREL_RST_REG;
      end else if (acc_wr) begin
         if (address == `TREL_OFS_CTRL)
            ctrl_q <= (ctrl_q & ~wmask) | (writedata & wmask);
         if (address == `TREL_OFS_EVENT_CONTROL_REG)
            event_control_reg_q <= (event_control_reg_q & ~wmask) | (writedata & wmask);
         if (address == `TREL_OFS_CHEV)
            chev_q <= (chev_q & ~wmask) | (writedata & wmask);
      end
   end

   // One-shot command pulse, live the cycle after the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         cmd_pulse_q <= 1'b0;
      else
         cmd_pulse_q <= acc_wr && address == `TREL_OFS_CMD && byteenable[0]
            && writedata[`TREL_CMD_LSB +: 3] == `TREL_CMD_DMA_ONE_SHOT;
   end

   // Pending update in one-shot mode; a new update beats the fire
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         os_pend_q <= 1'b0;
      else
         os_pend_q <= (os_pend_q && !cmd_pulse_q) || (dma_one_shot_mode && (upd_ovf || upd_retrig));
   end

   // Acknowledge seen during ramp B or down-count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ack_seen_q <= 1'b0;
      else if (start_b || start_a)
         ack_seen_q <= 1'b0;
      else if (any_ack)
         ack_seen_q <= 1'b1;
   end

   // Overflow request cause
   always_comb begin
      if (circ_act)
         // ramp A or up-count, only after an ack
         ovf_set = start_a && ack_seen_q;
      else if (dma_one_shot_mode)
         ovf_set = cmd_pulse_q && (os_pend_q || upd_ovf || upd_retrig);
      else
         ovf_set = upd_ovf || upd_retrig;
   end

   // ack clears, a new set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ovf_req_q <= 1'b0;
      else
         ovf_req_q <= ovf_set || (ovf_req_q && !dma_ovf_ack);
   end

   // Per-channel DMA request
   for (genvar i = 0; i < CH; i++) begin : g_mc
      always_comb begin
         if (capt_sel[i]) begin
            mc_set[i] = cap_valid[i];
            mc_clr[i] = cc_read[i];
         end else if (circ_mode && circ_en[i]) begin
            mc_set[i] = start_b;
            mc_clr[i] = dma_mc_ack[i];
         end else begin
            mc_set[i] = mc_evt[i] && !dma_one_shot_mode;
            mc_clr[i] = dma_mc_ack[i];
         end
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n)
            mc_req_q[i] <= 1'b0;
         else
            mc_req_q[i] <= mc_set[i] || (mc_req_q[i] && !mc_clr[i]);
      end
   end

   always_comb begin
      flag_set = '0;
      flag_set[`TREL_INT_OVF] = upd_ovf;
      flag_set[`TREL_INT_TRG] = upd_retrig;
      flag_set[`TREL_INT_CNT] = cnt_evt;
      flag_set[`TREL_INT_ERR] = cap_err;
      flag_set[`TREL_INT_DFS] = dbg_fault;
      flag_set[`TREL_INT_FLTA] = rec_fault[0];
      flag_set[`TREL_INT_FLTB] = rec_fault[1];
      flag_set[`TREL_INT_NRF0] = nr_fault[0] || evi.nrf[0] || |evi.nrfch;
      flag_set[`TREL_INT_NRF1] = nr_fault[1] || evi.nrf[1];
      flag_set[`TREL_INT_MC_LSB +: CH] = mc_evt | cap_valid;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flag_q <= '0;
      else if (acc_wr && address == `TREL_OFS_IRQ_FLAG_REG)
         flag_q <= flag_set | (flag_q & ~(writedata[NF-1:0] & wmask[NF-1:0]));
      else
         flag_q <= flag_set | flag_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         en_q <= '0;
      else if (acc_wr && address == `TREL_OFS_IRQ_ENABLE_SET_REG)
         en_q <= en_q | (writedata[NF-1:0] & wmask[NF-1:0]);
      else if (acc_wr && address == `TREL_OFS_IRQ_ENABLE_CLEAR_REG)
         en_q <= en_q & ~(writedata[NF-1:0] & wmask[NF-1:0]);
   end

   // stored level, holds with clock stopped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_q <= 1'b0;
      else
         irq_q <= |(flag_q & en_q);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_ovf_q <= 1'b0;
         ev_trg_q <= 1'b0;
         ev_cnt_q <= 1'b0;
         ev_mc_q <= '0;
      end else begin
         ev_ovf_q <= upd_ovf && event_control_reg_q[`TREL_EV_OVFEO];
         ev_trg_q <= upd_retrig && event_control_reg_q[`TREL_EV_TRGEO];
         ev_cnt_q <= cnt_evt && event_control_reg_q[`TREL_EV_CNTEO];
         ev_mc_q <= (mc_evt | cap_valid) & event_control_reg_q[`TREL_EV_MCEO_LSB +: CH];
      end
   end

   // Input event decoder wiring
   assign evi.ev0 = ev_sync_q[0];
   assign evi.ev1 = ev_sync_q[1];
   assign evi.mc = ev_sync_q[CH+1:2];
   assign evi.act0 = trel_ev0_act_e'(event_control_reg_q[`TREL_EV_ACT0_LSB +: 3]);
   assign evi.act1 = trel_ev1_act_e'(event_control_reg_q[`TREL_EV_ACT1_LSB +: 3]);
   assign evi.tcei = event_control_reg_q[`TREL_EV_TCEI_LSB +: 2];
   assign evi.mcei = event_control_reg_q[`TREL_EV_MCEI_LSB +: CH];
   assign evi.chev = chev_q[2*CH-1:0];
   assign evi.tick = presc_tick;
   assign evi.limit = count_limit;

   trel_ev_dec #(.CH(CH)) u_dec (
      .clk(clk),
      .rst_n(rst_n),
      .e(evi.dcd)
   );

   // Outputs, all flop-driven
   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign dma_ovf_req = ovf_req_q;
   assign dma_mc_req = mc_req_q;
   assign irq = irq_q;
   assign ev_ovf_out = ev_ovf_q;
   assign ev_trg_out = ev_trg_q;
   assign ev_cnt_out = ev_cnt_q;
   assign ev_mc_out = ev_mc_q;
   assign act_retrig = evi.retrig;
   assign act_dir_down = evi.dir_down;
   assign act_stop = evi.stop;
   assign act_dec = evi.dec;
   assign act_ppw = evi.ppw;
   assign act_step = evi.step;
   assign act_start = evi.start;
   assign act_inc = evi.inc;
   assign act_count = evi.count;
   assign act_capture = evi.cap;
   assign act_rec_fault = evi.recf;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence os_armed_s;
      dma_one_shot_mode && !circ_act && os_pend_q ##1 cmd_pulse_q;
   endsequence

   ovf_cont_a: assert property (
      !dma_one_shot_mode && !circ_act && (upd_ovf || upd_retrig) |=> dma_ovf_req)
      else $error("overflow request missing in continuous mode");
   ovf_oneshot_a: assert property (os_armed_s |=> dma_ovf_req)
      else $error("one-shot command did not fire request");
   ovf_ack_a: assert property (dma_ovf_req && dma_ovf_ack && !ovf_set |=> !dma_ovf_req)
      else $error("overflow request survived acknowledge");
   mc_block_a: assert property (
      dma_one_shot_mode && !capt_sel[0] && !(circ_mode && circ_en[0]) |=> !$rose(dma_mc_req[0]))
      else $error("compare request in one-shot mode");
   cap_req_a: assert property (capt_sel[CH/2] && cap_valid[CH/2] |=> dma_mc_req[CH/2])
      else $error("capture request missing");
   irq_level_a: assert property (|(flag_q & en_q) |=> irq)
      else $error("interrupt not raised for enabled flag");
   flag_clear_a: assert property (
      acc_wr && address == `TREL_OFS_IRQ_FLAG_REG && writedata[0] && byteenable[0] && !upd_ovf
      |=> !flag_q[`TREL_INT_OVF])
      else $error("flag not cleared by write one");
   ev_gate_a: assert property (!event_control_reg_q[`TREL_EV_OVFEO] |=> !ev_ovf_out)
      else $error("overflow event passed while disabled");
endmodule

// ### rtl/trel_params.svh
`ifndef TREL_PARAMS_SVH
`define TREL_PARAMS_SVH

// Register byte offsets
`define TREL_OFS_CTRL 6'h00
`define TREL_OFS_CMD 6'h04
`define TREL_OFS_EVENT_CONTROL_REG 6'h08
`define TREL_OFS_IRQ_ENABLE_CLEAR_REG 6'h0c
`define TREL_OFS_IRQ_ENABLE_SET_REG 6'h10
`define TREL_OFS_IRQ_FLAG_REG 6'h14
`define TREL_OFS_STATUS 6'h18
`define TREL_OFS_CHEV 6'h1c

// Control register fields
`define TREL_CTRL_DMA_ONE_SHOT_MODE 0
`define TREL_CTRL_WAVE_LSB 2
`define TREL_CTRL_CIRC_LSB 8
`define TREL_CTRL_CAPT_LSB 16

// Command field and the one-shot DMA command code
`define TREL_CMD_LSB 5
`define TREL_CMD_DMA_ONE_SHOT 3'h5

// Event control fields
`define TREL_EV_ACT0_LSB 0
`define TREL_EV_ACT1_LSB 3
`define TREL_EV_OVFEO 8
`define TREL_EV_TRGEO 9
`define TREL_EV_CNTEO 10
`define TREL_EV_TCEI_LSB 14
`define TREL_EV_MCEI_LSB 16
`define TREL_EV_MCEO_LSB 24

// Interrupt flag / enable bit positions
`define TREL_INT_OVF 0
`define TREL_INT_TRG 1
`define TREL_INT_CNT 2
`define TREL_INT_ERR 3
`define TREL_INT_DFS 11
`define TREL_INT_FLTA 12
`define TREL_INT_FLTB 13
`define TREL_INT_NRF0 14
`define TREL_INT_NRF1 15
`define TREL_INT_MC_LSB 16

// Reset values
`define TREL_RST_REG 32'h0000_0000

`endif

// ### rtl/trel_pkg.sv
package trel_pkg;
   typedef enum logic [2:0] {
      EV1_OFF, EV1_RETRIG, EV1_DIR, EV1_STOP, EV1_DEC, EV1_PPW, EV1_FAULT
   } trel_ev1_act_e;
   typedef enum logic [2:0] {
      EV0_OFF, EV0_RETRIG, EV0_COUNT, EV0_START, EV0_INC, EV0_ACTIVE, EV0_FAULT
   } trel_ev0_act_e;
   typedef enum logic [1:0] {
      WAVE_OTHER, WAVE_TWO_RAMP, WAVE_TWO_RAMP_ALT, WAVE_DUAL_BOTH
   } trel_wave_e;
   typedef enum logic [1:0] {
      CHEV_CAPTURE, CHEV_REC_FAULT, CHEV_NR_FAULT, CHEV_OFF
   } trel_chev_e;
endpackage

// ### rtl/trel_ev_if.sv
interface trel_ev_if #(parameter int CH = 4);
   // Synchronised event levels and their configuration
   logic ev0;
   logic ev1;
   logic [CH-1:0] mc;
   trel_pkg::trel_ev0_act_e act0;
   trel_pkg::trel_ev1_act_e act1;
   logic [1:0] tcei;
   logic [CH-1:0] mcei;
   logic [2*CH-1:0] chev;
   logic tick;
   logic limit;
   // Decoded actions toward the counter core
   logic retrig;
   logic dir_down;
   logic stop;
   logic dec;
   logic ppw;
   logic step;
   logic start;
   logic inc;
   logic count;
   logic [1:0] nrf;
   logic [CH-1:0] cap;
   logic [CH-1:0] recf;
   logic [CH-1:0] nrfch;
   modport top (output ev0, ev1, mc, act0, act1, tcei, mcei, chev, tick, limit,
      input retrig, dir_down, stop, dec, ppw, step, start, inc, count, nrf, cap, recf, nrfch);
   modport dcd (input ev0, ev1, mc, act0, act1, tcei, mcei, chev, tick, limit,
      output retrig, dir_down, stop, dec, ppw, step, start, inc, count, nrf, cap, recf, nrfch);
endinterface

// ### rtl/trel_ev_dec.sv
module trel_ev_dec #(parameter int CH = 4) (
   input wire logic clk,
   input wire logic rst_n,
   trel_ev_if.dcd e
);
   import trel_pkg::*;
   logic ev0_q, ev1_q, run_q;
   logic [CH-1:0] mc_q;
   logic rise0, rise1, fall1;
   logic [CH-1:0] mc_rise;

   assign rise0 = e.ev0 & ~ev0_q & e.tcei[0];
   assign rise1 = e.ev1 & ~ev1_q & e.tcei[1];
   assign fall1 = ~e.ev1 & ev1_q & e.tcei[1];
   assign mc_rise = e.mc & ~mc_q & e.mcei;

   // Edge history of the event levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev0_q <= 1'b0;
         ev1_q <= 1'b0;
         mc_q <= '0;
      end else begin
         ev0_q <= e.ev0;
         ev1_q <= e.ev1;
         mc_q <= e.mc;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         e.dir_down <= 1'b0;
         e.stop <= 1'b0;
         e.dec <= 1'b0;
         e.ppw <= 1'b0;
      end else begin
         e.stop <= rise1 && e.act1 == EV1_STOP;
         e.dec <= rise1 && e.act1 == EV1_DEC;
         // Both edges: period on rise, pulse width on fall
         e.ppw <= (rise1 | fall1) && e.act1 == EV1_PPW;
         if (e.act1 == EV1_DIR && e.tcei[1])
            e.dir_down <= e.ev1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         e.step <= 1'b0;
         e.inc <= 1'b0;
         e.count <= 1'b0;
      end else begin
         e.step <= rise0 && e.act0 == EV0_COUNT;
         e.inc <= rise0 && e.act0 == EV0_INC;
         e.count <= e.ev0 && e.tcei[0] && e.tick && e.act0 == EV0_ACTIVE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         e.start <= 1'b0;
      end else begin
         e.start <= rise0 && !run_q && e.act0 == EV0_START;
         if (e.limit)
            run_q <= 1'b0;
         else if (rise0 && e.act0 == EV0_START)
            run_q <= 1'b1;
      end
   end

   // Shared re-trigger and fault actions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         e.retrig <= 1'b0;
         e.nrf <= 2'h0;
      end else begin
         e.retrig <= (rise0 && e.act0 == EV0_RETRIG) || (rise1 && e.act1 == EV1_RETRIG);
         e.nrf <= {rise1 && e.act1 == EV1_FAULT, rise0 && e.act0 == EV0_FAULT};
      end
   end

   for (genvar i = 0; i < CH; i++) begin : g_ch
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            e.cap[i] <= 1'b0;
            e.recf[i] <= 1'b0;
            e.nrfch[i] <= 1'b0;
         end else begin
            e.cap[i] <= mc_rise[i] && e.chev[2*i +: 2] == CHEV_CAPTURE;
            e.recf[i] <= mc_rise[i] && e.chev[2*i +: 2] == CHEV_REC_FAULT;
            e.nrfch[i] <= mc_rise[i] && e.chev[2*i +: 2] == CHEV_NR_FAULT;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   start_once_a: assert property (run_q && !e.limit |=> !e.start)
      else $error("start action repeated while running");
   count_active_a: assert property (
      e.act0 == EV0_ACTIVE && e.tcei[0] && e.ev0 && e.tick |=> e.count)
      else $error("active count step missing");
endmodule

// ### tb/trel_dma_model.sv
module trel_dma_model #(parameter int CH = 4) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] lat,
   input wire logic [CH:0] req,
   output logic [CH:0] ack
);
   timeunit 1ns;
   timeprecision 1ps;
   // One acknowledger per request line; lat sets how long it stalls
   for (genvar i = 0; i <= CH; i++) begin : g_line
      logic [3:0] cnt_q;
      logic ack_q;
      assign ack[i] = ack_q;
      // One pulse per request, none while the request drains
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
         end else begin
            ack_q <= req[i] && !ack_q && cnt_q >= lat;
            if (!req[i] || ack_q) begin
               cnt_q <= 4'h0;
            end else if (cnt_q < lat) begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
endmodule

// ### tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] rd;
   logic [32:0] src = 33'h0;
   logic [3:0] lat = 4'h0;
   wire [31:0] readdata;
   wire waitrequest;
   wire [4:0] ack;
   wire [4:0] req;
   wire [24:0] obs;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;

   trel_top i_trel_top (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .upd_ovf(src[0]), .upd_retrig(src[1]), .cnt_evt(src[2]),
      .cap_err(src[3]), .dbg_fault(src[4]), .rec_fault(src[6:5]), .nr_fault(src[8:7]),
      .mc_evt(src[12:9]), .cap_valid(src[16:13]), .cc_read(src[20:17]),
      .ramp_a_start(src[21]), .ramp_b_start(src[22]), .up_start(src[23]),
      .down_start(src[24]), .presc_tick(src[25]), .count_limit(src[26]),
      .dma_ovf_ack(ack[0]), .dma_mc_ack(ack[4:1]), .dma_ovf_req(req[0]),
      .dma_mc_req(req[4:1]), .ev_in0(src[27]), .ev_in1(src[28]), .ev_mc_in(src[32:29]),
      .ev_ovf_out(obs[17]), .ev_trg_out(obs[18]), .ev_cnt_out(obs[19]),
      .ev_mc_out(obs[23:20]), .act_retrig(obs[0]), .act_dir_down(obs[1]),
      .act_stop(obs[2]), .act_dec(obs[3]), .act_ppw(obs[4]), .act_step(obs[5]),
      .act_start(obs[6]), .act_inc(obs[7]), .act_count(obs[8]),
      .act_rec_fault(obs[12:9]), .act_capture(obs[16:13]), .irq(obs[24]));
   trel_dma_model i_trel_dma_model (.clk(clk), .rst_n(reset_n), .lat(lat), .req(req),
      .ack(ack));

   always #5 clk = ~clk;
   // Hang guard, far beyond the roughly 1100 cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   task automatic close_out();
      $display("mismatches %0d of %0d compares", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bus cycle; the slave alone decides when waitrequest drops
   task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d);
      address <= a;
      write <= w;
      read <= ~w;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse(input int i);
      src[i] <= 1'b1;
      @(posedge clk);
      src[i] <= 1'b0;
   endtask

   // OR of the observed outputs over n cycles, so one-cycle pulses are caught
   task automatic watch(input int n, output logic [24:0] s);
      s = 25'h0;
      repeat (n) begin
         @(posedge clk);
         s = s | obs;
      end
   endtask

   task automatic s_flags();
      logic [24:0] s;
      int f;
      for (int en = 0; en < 2; en++) begin
         av(6'h08, 1'b1, en ? 32'h0f00_0700 : 32'h0);
         for (int i = 0; i < 13; i++) begin
            f = i < 4 ? i : i + 7;
            av(6'h14, 1'b1, 32'hffff_ffff);
            pulse(i);
            watch(3, s);
            chk(32'(s[24:17]), en && (i < 3 || i > 8) ? 32'h1 << (i < 3 ? i : i - 6) : 0);
            av(6'h14, 1'b0, 32'h0);
            chk(rd, 32'h1 << f);
         end
      end
   endtask

   task automatic s_irq();
      av(6'h10, 1'b1, 32'h2);
      av(6'h10, 1'b0, 32'h0);
      chk(rd, 32'h2);
      pulse(1);
      tk(3);
      chk(32'(obs[24]), 32'h1);
      av(6'h14, 1'b1, 32'hffff_fffd);
      tk(2);
      chk(32'(obs[24]), 32'h1);
      av(6'h0c, 1'b1, 32'h2);
      tk(2);
      chk(32'(obs[24]), 32'h0);
      av(6'h10, 1'b1, 32'h2);
      tk(2);
      chk(32'(obs[24]), 32'h1);
      av(6'h14, 1'b1, 32'h2);
      tk(2);
      chk(32'(obs[24]), 32'h0);
   endtask

   // Slow acknowledger, so requests are seen standing before they clear
   task automatic s_dma();
      lat <= 4'h6;
      pulse(0);
      tk(2);
      chk(32'(req[0]), 32'h1);
      tk(10);
      chk(32'(req[0]), 32'h0);
      pulse(10);
      tk(2);
      chk(32'(req[2]), 32'h1);
      tk(10);
      chk(32'(req[2]), 32'h0);
      av(6'h00, 1'b1, 32'h1);
      pulse(10);
      pulse(0);
      tk(4);
      chk(32'(req), 32'h0);
      av(6'h04, 1'b1, 32'ha0);
      tk(2);
      chk(32'(req[0]), 32'h1);
      tk(10);
      chk(32'(req[0]), 32'h0);
      lat <= 4'h0;
   endtask

   // Channel 2 events: capture, both faults, then capture with input disabled
   task automatic s_cap();
      logic [24:0] s;
      av(6'h00, 1'b1, 32'h0004_0001);
      for (int c = 0; c < 4; c++) begin
         av(6'h1c, 1'b1, 32'hcf | (32'(c % 3) << 4));
         av(6'h14, 1'b1, 32'hffff_ffff);
         av(6'h08, 1'b1, c < 3 ? 32'h0004_0000 : 32'h0);
         src[31] <= 1'b1;
         watch(8, s);
         src[31] <= 1'b0;
         tk(4);
         chk(32'({s[15], s[11]}), c == 0 ? 32'h2 : c == 1 ? 32'h1 : 32'h0);
         av(6'h14, 1'b0, 32'h0);
         chk(32'(rd[14]), 32'(c == 2));
      end
      pulse(15);
      tk(8);
      chk(32'(req[3]), 32'h1);
      pulse(19);
      tk(2);
      chk(32'(req[3]), 32'h0);
   endtask

   // Counter event actions with the prescaled tick held active
   task automatic s_act();
      logic [24:0] s;
      int b;
      src[25] <= 1'b1;
      for (int g = 0; g < 2; g++) begin
         for (int e = 0; e < 2; e++) begin
            for (int c = 1; c < 6; c++) begin
               b = e ? c - 1 : (c == 1 ? 0 : c + 3);
               av(6'h08, 1'b1, (e ? 32'(c) << 3 : 32'(c)) | (g ? 0 : 32'h1 << (14 + e)));
               src[27 + e] <= 1'b1;
               watch(8, s);
               chk(32'(s[b]), 32'(g == 0));
               src[27 + e] <= 1'b0;
               tk(5);
               watch(4, s);
               chk(32'(s[b] && b != 1), 32'h0);
            end
         end
      end
      // Second rise while running is ignored; the limit rearms start
      av(6'h08, 1'b1, 32'h4003);
      src[27] <= 1'b1;
      watch(8, s);
      chk(32'(s[6]), 32'h0);
      src[27] <= 1'b0;
      pulse(26);
      tk(4);
      src[27] <= 1'b1;
      watch(8, s);
      chk(32'(s[6]), 32'h1);
      src[27] <= 1'b0;
      tk(4);
      src[25] <= 1'b0;
   endtask

   // Normal mode, both two-ramp modes and dual-slope, channel 0 circular
   task automatic s_circ();
      for (int w = 0; w < 4; w++) begin
         av(6'h00, 1'b1, 32'h100 | (32'(w) << 2));
         lat <= 4'h0;
         pulse(9);
         tk(1);
         chk(32'(req[1]), 32'(w == 0));
         tk(4);
         pulse(w == 3 ? 24 : 22);
         tk(2);
         chk(32'(req[1]), 32'(w != 0));
         tk(4);
         pulse(w == 3 ? 23 : 21);
         tk(2);
         chk(32'(req[0]), 32'(w != 0));
         lat <= 4'hf;
         tk(6);
         pulse(w == 3 ? 24 : 22);
         pulse(w == 3 ? 23 : 21);
         tk(2);
         chk(32'(req[0]), 32'h0);
         tk(24);
      end
   endtask

   initial begin
      tk(4);
      reset_n <= 1'b1;
      tk(3);
      s_flags();
      s_irq();
      s_dma();
      s_cap();
      s_act();
      s_circ();
      close_out();
   end
endmodule
